// *** rtl/apc_pkg.sv ***
// shared constants and carrier types of the parallel converter control
package apc_pkg;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CONV_MAX_US  = 6;
  // longest time as a whole number of clock cycles (time in us times clock in MHz)
  localparam int unsigned CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
  localparam int unsigned INT_DIV      = 16;
  localparam logic [RES_W-1:0] CODE_ALL_ONES  = 10'h3FF;
  localparam logic [RES_W-1:0] CODE_ALL_ZEROS = 10'h000;

  typedef struct packed {
    logic             over_range;
    logic             under_range;
    logic [RES_W-1:0] sample;
  } apc_analog_t;

  typedef struct packed {
    logic [RES_W-1:0] data;
    logic             oe;
  } apc_bus_t;

  typedef enum logic [2:0] {
    ST_TRACK   = 3'b001,
    ST_CONVERT = 3'b010,
    ST_DONE    = 3'b100
  } apc_state_t;
endpackage

// *** rtl/apc_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module apc_pin_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts once the second and third stage agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level_o[i] <= s3[i];
        end
      end
    end
  end
endmodule

// *** rtl/apc_conv_ctrl.sv ***
// control of a 10-bit successive-approximation converter with parallel port
`timescale 1ns/1ns
module apc_conv_ctrl
  import apc_pkg::*;
#(
  parameter int unsigned INT_DIVIDE = apc_pkg::INT_DIV
) (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      sel_n_i,
  input  wire logic                      wr_n_i,
  input  wire logic                      rd_n_i,
  input  wire logic                      ext_clk_sel_i,
  input  wire logic                      ext_conv_clock_in_i,
  input  wire apc_pkg::apc_analog_t      analog_i,
  output logic [apc_pkg::RES_W-1:0]      result_bus_o,
  output logic [apc_pkg::RES_W-1:0]      result_bus_oe_o,
  output logic                           conv_done_n_o,
  output logic                           hold_o,
  output logic                           timeout_o
);
  import apc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sel_n_s;
  logic       wr_n_s;
  logic       rd_n_s;
  logic       ext_clk_s;

  apc_pin_sync #(.W(4), .INIT(4'hE)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pin_i    ({sel_n_i, wr_n_i, rd_n_i, ext_conv_clock_in_i}),
    .level_o  (pins_s)
  );
  assign {sel_n_s, wr_n_s, rd_n_s, ext_clk_s} = pins_s;

  logic wr_n_d;
  logic ext_clk_d;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_n_d    <= 1'b1;
      ext_clk_d <= 1'b0;
    end else begin
      wr_n_d    <= wr_n_s;
      ext_clk_d <= ext_clk_s;
    end
  end

  // write rising edge counts only with select low
  logic start_req;
  assign start_req = !wr_n_d && wr_n_s && !sel_n_s;
  logic read_act;
  assign read_act = !sel_n_s && !rd_n_s;

  // ----------------------------------------------------------------
  // conversion clock enable
  // ----------------------------------------------------------------
  logic [7:0] div_cnt;
  logic       int_tick;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt  <= 8'h00;
      int_tick <= 1'b0;
    end else if (div_cnt == 8'(INT_DIVIDE - 1)) begin
      div_cnt  <= 8'h00;
      int_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
      int_tick <= 1'b0;
    end
  end

  // host keeps the external clock at or below its limit
  logic conv_tick;
  assign conv_tick = ext_clk_sel_i ? (ext_clk_s && !ext_clk_d) : int_tick;

  // ----------------------------------------------------------------
  // state machine and successive approximation
  // ----------------------------------------------------------------
  apc_state_t       state;
  logic [3:0]       bit_idx;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] held;
  logic             held_over;
  logic             held_under;
  logic [RES_W-1:0] latch;
  logic [9:0]       wd_cnt;

  function automatic logic [RES_W-1:0] trial(input logic [RES_W-1:0] s,
                                             input logic [3:0] i);
    trial = s | (RES_W'(1) << i);
  endfunction

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state   <= ST_TRACK;
      bit_idx <= 4'h0;
      sar     <= CODE_ALL_ZEROS;
      hold_o  <= 1'b0;
    end else begin
      unique case (state)
        ST_TRACK: begin
          hold_o <= 1'b0;
          if (start_req) begin
            state   <= ST_CONVERT;
            hold_o  <= 1'b1;
            bit_idx <= 4'(RES_W - 1);
            sar     <= CODE_ALL_ZEROS;
          end
        end
        ST_CONVERT: begin
          if (conv_tick || wd_cnt == 10'(CONV_MAX_CYC - 2)) begin
            if (trial(sar, bit_idx) <= held) begin
              sar <= trial(sar, bit_idx);
            end
            if (bit_idx == 4'h0) begin
              state <= ST_DONE;
            end else begin
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        ST_DONE: begin
          state  <= ST_TRACK;
          hold_o <= 1'b0;
        end
        default: state <= ST_TRACK;
      endcase
    end
  end

  // sample held at the start of hold mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      held       <= CODE_ALL_ZEROS;
      held_over  <= 1'b0;
      held_under <= 1'b0;
    end else if (state == ST_TRACK && start_req) begin
      held       <= analog_i.sample;
      held_over  <= analog_i.over_range;
      held_under <= analog_i.under_range;
    end
  end

  // watchdog forcing one bit per cycle near the time limit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_cnt    <= 10'h000;
      timeout_o <= 1'b0;
    end else if (state == ST_CONVERT) begin
      if (wd_cnt != 10'(CONV_MAX_CYC - 2)) begin
        wd_cnt <= wd_cnt + 10'h001;
      end else begin
        timeout_o <= 1'b1;
      end
    end else begin
      wd_cnt <= 10'h000;
      if (start_req) begin
        timeout_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output latch, done flag and data bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch <= CODE_ALL_ZEROS;
    end else if (state == ST_DONE) begin
      if (held_over) begin
        latch <= CODE_ALL_ONES;
      end else if (held_under) begin
        latch <= CODE_ALL_ZEROS;
      end else begin
        latch <= sar;
      end
    end
  end

  // done falls the cycle after the latch loads; set wins over read clear
  logic latch_valid;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_valid   <= 1'b0;
      conv_done_n_o <= 1'b1;
    end else begin
      latch_valid <= (state == ST_DONE);
      if (latch_valid) begin
        conv_done_n_o <= 1'b0;
      end else if (read_act || start_req) begin
        conv_done_n_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_bus_o    <= CODE_ALL_ZEROS;
      result_bus_oe_o <= '0;
    end else begin
      result_bus_o    <= read_act ? latch : CODE_ALL_ZEROS;
      result_bus_oe_o <= {RES_W{read_act}};
    end
  end
endmodule

// *** verification/apc_conv_checker.sv ***
// port assertions for the converter control
`timescale 1ns/1ns
module apc_conv_checker
  import apc_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             resetn_i,
  input wire logic             sel_n_i,
  input wire logic             wr_n_i,
  input wire logic             rd_n_i,
  input wire logic [RES_W-1:0] result_bus_o,
  input wire logic [RES_W-1:0] result_bus_oe_o,
  input wire logic             conv_done_n_o,
  input wire logic             hold_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_hold_on_write: assert property ($rose(hold_o) |-> !$past(wr_n_i,6) && !$past(sel_n_i,4))
    else $error("hold without selected write");
  chk_track_idle: assert property ((!hold_o && wr_n_i) [*8] |=> !hold_o)
    else $error("hold left track without write");
  chk_conv_time: assert property ($rose(hold_o) |-> ##[1:600] !hold_o)
    else $error("conversion too long");
  chk_done_after_hold: assert property ($fell(hold_o) |-> ##[1:4] !conv_done_n_o)
    else $error("done missing after conversion");
  chk_read_clears: assert property ($rose(result_bus_oe_o[0]) |-> conv_done_n_o)
    else $error("done still low in read");
  chk_oe_needs_read: assert property ($rose(result_bus_oe_o[0]) |-> !$past(rd_n_i,3) && !$past(sel_n_i,3))
    else $error("bus driven without read");
  chk_bus_quiet: assert property (result_bus_oe_o == '0 |-> result_bus_o == '0)
    else $error("data while released");
  chk_oe_release: assert property (rd_n_i [*8] |-> result_bus_oe_o == '0)
    else $error("bus held after read");
  cov_conv: cover property ($rose(hold_o));
  cov_done: cover property ($fell(conv_done_n_o));
  cov_read: cover property ($rose(result_bus_oe_o[0]));
endmodule
bind apc_conv_ctrl apc_conv_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .sel_n_i(sel_n_i),
  .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .result_bus_o(result_bus_o), .hold_o(hold_o),
  .result_bus_oe_o(result_bus_oe_o), .conv_done_n_o(conv_done_n_o));

// *** verification/apc_host_model.sv ***
// host processor model: select, strobes and conversion clock
`timescale 1ns/1ns
module apc_host_model
  import apc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             ext_run_i,
  input  wire logic [RES_W-1:0] bus_i,
  input  wire logic [RES_W-1:0] bus_oe_i,
  output logic                  sel_n_o = 1'b1,
  output logic                  wr_n_o = 1'b1,
  output logic                  rd_n_o = 1'b1,
  output logic                  ext_clk_o = 1'b0
);
  int unsigned div = 0;
  // about 4.2 MHz, stands low while ext_run_i is low
  always @(posedge clk_i) begin
    div <= (div == 11) ? 0 : div + 1;
    ext_clk_o <= ext_run_i && (ext_clk_o ^ (div == 11));
  end
  task automatic strobe(input logic sel_n, input logic rd, output logic [RES_W-1:0] q,
                        output logic oe);
    @(posedge clk_i);
    sel_n_o <= sel_n;
    @(posedge clk_i);
    rd_n_o <= !rd;
    wr_n_o <= rd;
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    q = bus_i;
    oe = bus_oe_i[0];
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    sel_n_o <= 1'b1;
  endtask
endmodule

// *** verification/adc_parallel_convert_control_tb.sv ***
// self-checking bench for the converter control
`timescale 1ns/1ns
module adc_parallel_convert_control_tb;
  import apc_pkg::*;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
  logic             clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic             sel_n, wr_n, rd_n, ext_clk, done_n, hold, tmo, qoe;
  logic             ext_sel = 1'b0;
  logic             ext_run = 1'b0;
  logic [RES_W-1:0] bus, oe, q;
  apc_analog_t      analog = '0;
  int               failures = 0;
  int               n_tests = 0;
  always #5 clk_i = ~clk_i;
  apc_conv_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .sel_n_i(sel_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .ext_clk_sel_i(ext_sel), .ext_conv_clock_in_i(ext_clk), .analog_i(analog),
    .result_bus_o(bus), .result_bus_oe_o(oe), .conv_done_n_o(done_n), .hold_o(hold),
    .timeout_o(tmo));
  apc_host_model host (.clk_i(clk_i), .ext_run_i(ext_run), .bus_i(bus), .bus_oe_i(oe),
    .sel_n_o(sel_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .ext_clk_o(ext_clk));
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // start, optionally write again mid-conversion, wait for done, read back
  task automatic convert(input apc_analog_t a, input logic xs, input logic twice);
    int k;
    @(posedge clk_i);
    analog <= a;
    ext_sel <= xs;
    ext_run <= xs;
    host.strobe(1'b0, 1'b0, q, qoe);
    `CHK("hold", 1'b1, hold)
    if (twice) host.strobe(1'b0, 1'b0, q, qoe);
    for (k = 0; k < 600 && done_n !== 1'b0; k++) @(negedge clk_i);
    `CHK("done", 1'b0, done_n)
    if (k >= 600) wrap_up();
    `CHK("timeout", 1'b0, tmo)
    host.strobe(1'b0, 1'b1, q, qoe);
    ext_run <= 1'b0;
    `CHK("result", a.over_range ? 10'h3FF : a.under_range ? 10'h000 : a.sample, q)
    `CHK("done_read", 1'b1, done_n)
  endtask
  task automatic sc_codes();
    apc_analog_t tab [6] = '{'{1'b0, 1'b0, 10'h2A5}, '{1'b1, 1'b0, 10'h155},
      '{1'b0, 1'b1, 10'h0AA}, '{1'b1, 1'b1, 10'h123}, '{1'b0, 1'b0, 10'h001},
      '{1'b0, 1'b0, 10'h200}};
    for (int i = 0; i < 6; i++) convert(tab[i], i[0], 1'b0);
  endtask
  task automatic sc_busy();
    convert('{1'b0, 1'b0, 10'h1C3}, 1'b0, 1'b1);
  endtask
  task automatic sc_unselected();
    host.strobe(1'b1, 1'b0, q, qoe);
    repeat (20) @(posedge clk_i);
    `CHK("hold_nosel", 1'b0, hold)
    host.strobe(1'b1, 1'b1, q, qoe);
    `CHK("oe_nosel", 1'b0, qoe)
    `CHK("bus_nosel", 10'h000, q)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    `CHK("done_rst", 1'b1, done_n)
    sc_codes();
    sc_busy();
    sc_unselected();
    wrap_up();
  end
endmodule
